// File: rtl/picw_prog.sv
`timescale 1ns/10ps
module picw_prog (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wr_n,
   input wire logic i_rd_n,
   input wire logic i_cs_n,
   input wire logic i_a0,
   input wire logic [7:0] i_data,
   input wire logic [7:0] i_req,
   input wire logic [7:0] i_in_service,
   input wire logic [2:0] i_cas,
   input wire logic i_slave_program_buffer_enable_pin,
   input wire logic i_vec_sel,
   input wire logic [2:0] i_vec_level,
   output logic [7:0] o_rdata,
   output logic [7:0] o_vec_byte,
   output logic [7:0] o_pending,
   output logic o_init_done,
   output logic o_level_trig,
   output logic o_special_nest,
   output logic o_auto_eoi,
   output logic o_mode86,
   output logic o_master,
   output logic o_slave_program_buffer_enable_oe,
   output logic o_smm,
   output logic o_rot_auto_end_bit,
   output logic [2:0] o_lowest,
   output logic [7:0] o_mask,
   output logic [7:0] o_slave_map,
   output logic o_vec_drive,
   output picw_pkg::picw_op_t o_op
);
   typedef enum {
      PICW_IDLE,
      PICW_WAIT_IW2,
      PICW_WAIT_IW3,
      PICW_WAIT_IW4,
      PICW_READY
   } picw_state_t;

   typedef struct packed {
      picw_state_t state;
      picw_pkg::picw_cfg_t cfg;
      picw_pkg::picw_bus_t bus;
      logic wr_prev;
      logic rd_prev;
      logic rearm;
      picw_pkg::picw_op_t op;
      logic [7:0] rdata;
      logic [7:0] vec_byte;
      logic vec_drive;
      logic [7:0] pending;
      logic init_done;
      logic master_out;
   } picw_prog_st_t;

   picw_prog_st_t st_q;
   picw_prog_st_t st_d;

   logic [7:0] req_s;
   logic [11:0] bus_s;
   logic [2:0] cas_s;
   logic sp_s;
   logic [7:0] pend_w;
   logic wr_rise;
   logic rd_fall;
   logic [7:0] dwr;
   logic is_master;

   // Host strobes and request pins cross in through two flops
   picw_sync #(.W(12)) u_bus_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async({~i_wr_n & ~i_cs_n, ~i_rd_n & ~i_cs_n, i_a0, i_data,
                1'b0}),
      .o_sync(bus_s)
   );

   picw_sync #(.W(12)) u_pin_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async({i_req, i_cas, i_slave_program_buffer_enable_pin}),
      .o_sync({req_s, cas_s, sp_s})
   );

   // One sense cell per request channel
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_edge
         picw_edge u_edge (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_req(req_s[g]),
            .i_level_mode(st_q.cfg.level_trig),
            .i_rearm(st_q.rearm),
            .i_clear(i_in_service[g]),
            .o_pending(pend_w[g])
         );
      end
   endgenerate

   // The write is taken at the end of the strobe, when data is settled
   assign wr_rise = st_q.wr_prev & ~bus_s[11];
   assign rd_fall = ~st_q.rd_prev & bus_s[10];
   assign dwr = st_q.bus.data;

   // Without buffered mode the strap pin decides master or slave
   assign is_master = st_q.cfg.buffered ? st_q.cfg.master : sp_s;

   always_comb begin
      st_d = st_q;
      st_d.wr_prev = bus_s[11];
      st_d.rd_prev = bus_s[10];
      st_d.rearm = 1'b0;
      st_d.op = '0;
      st_d.pending = pend_w;
      // Latch address and data while the strobe is active
      if (bus_s[11]) begin
         st_d.bus.a0 = bus_s[9];
         st_d.bus.data = bus_s[8:1];
      end
      if (wr_rise) begin
         if (!st_q.bus.a0 && dwr[picw_pkg::IW1_INIT_BIT]) begin
            // Restart from any state
            st_d.state = PICW_WAIT_IW2;
            st_d.rearm = 1'b1;
            st_d.cfg.mask = picw_pkg::MASK_RST;
            st_d.cfg.lowest = picw_pkg::LOWEST_RST;
            st_d.cfg.slave_id = picw_pkg::SLAVE_ID_RST;
            st_d.cfg.special_mask_bit = 1'b0;
            st_d.cfg.read_isr = 1'b0;
            st_d.cfg.rot_auto_end_bit = 1'b0;
            st_d.cfg.level_trig = dwr[picw_pkg::IW1_LEVEL_TRIGGER_BIT_BIT];
            st_d.cfg.adi4 = dwr[picw_pkg::IW1_ADI_BIT];
            st_d.cfg.single = dwr[picw_pkg::IW1_SINGLE_DEVICE_BIT_BIT];
            st_d.cfg.ic4 = dwr[picw_pkg::IW1_IC4_BIT];
            // Call-address bits A7..A5 share the word
            st_d.cfg.base_lo = {dwr[7:5], 5'h00};
            if (!dwr[picw_pkg::IW1_IC4_BIT]) begin
               st_d.cfg.special_nesting_bit = 1'b0;
               st_d.cfg.buffered = 1'b0;
               st_d.cfg.master = 1'b0;
               st_d.cfg.auto_end_bit = 1'b0;
               st_d.cfg.mode86 = 1'b0;
            end
         end else if (st_q.bus.a0) begin
            case (st_q.state)
               PICW_WAIT_IW2: begin
                  st_d.cfg.base_hi = dwr;
                  if (!st_q.cfg.single) begin
                     st_d.state = PICW_WAIT_IW3;
                  end else if (st_q.cfg.ic4) begin
                     st_d.state = PICW_WAIT_IW4;
                  end else begin
                     st_d.state = PICW_READY;
                  end
               end
               PICW_WAIT_IW3: begin
                  st_d.cfg.slave_map = dwr;
                  st_d.cfg.slave_id = dwr[2:0];
                  st_d.state = st_q.cfg.ic4 ? PICW_WAIT_IW4 : PICW_READY;
               end
               PICW_WAIT_IW4: begin
                  st_d.cfg.special_nesting_bit = dwr[picw_pkg::IW4_SPECIAL_NESTING_BIT_BIT];
                  st_d.cfg.buffered = dwr[picw_pkg::IW4_BUF_BIT];
                  st_d.cfg.master = dwr[picw_pkg::IW4_MS_BIT];
                  st_d.cfg.auto_end_bit = dwr[picw_pkg::IW4_AUTO_END_BIT_BIT];
                  st_d.cfg.mode86 = dwr[picw_pkg::IW4_UPM_BIT];
                  st_d.state = PICW_READY;
               end
               PICW_READY: begin
                  st_d.cfg.mask = dwr;
               end
               default: begin
                  // Select-high write before any init word is dropped
                  st_d.state = st_q.state;
               end
            endcase
         end else if (st_q.state == PICW_READY) begin
            if (!dwr[picw_pkg::OW_SEL_BIT]) begin
               // Second operation word: one-cycle command pulse
               st_d.op.valid = 1'b1;
               st_d.op.code = picw_pkg::picw_cmd_t'(dwr[7:5]);
               st_d.op.level = dwr[2:0];
               case (picw_pkg::picw_cmd_t'(dwr[7:5]))
                  picw_pkg::PICW_CMD_ROT_AUTO_END_BIT_SET: begin
                     st_d.cfg.rot_auto_end_bit = 1'b1;
                  end
                  picw_pkg::PICW_CMD_ROT_AUTO_END_BIT_CLR: begin
                     st_d.cfg.rot_auto_end_bit = 1'b0;
                  end
                  picw_pkg::PICW_CMD_SET_PRIO,
                  picw_pkg::PICW_CMD_ROT_SP_EOI: begin
                     st_d.cfg.lowest = dwr[2:0];
                  end
                  default: begin
                     st_d.cfg.rot_auto_end_bit = st_q.cfg.rot_auto_end_bit;
                  end
               endcase
            end else begin
               // Third operation word
               if (dwr[picw_pkg::OW3_SPECIAL_MASK_ENABLE_BIT]) begin
                  st_d.cfg.special_mask_bit = dwr[picw_pkg::OW3_SMM_BIT];
               end
               if (dwr[picw_pkg::OW3_RR_BIT]) begin
                  st_d.cfg.read_isr = dwr[picw_pkg::OW3_RIS_BIT];
               end
               st_d.op.poll = dwr[picw_pkg::OW3_POLL_BIT];
               st_d.op.valid = dwr[picw_pkg::OW3_POLL_BIT];
               st_d.op.code = picw_pkg::PICW_CMD_NOP;
            end
         end
      end
      // Status read source latched at the start of the read strobe
      if (rd_fall) begin
         if (bus_s[9]) begin
            st_d.rdata = st_q.cfg.mask;
         end else if (st_q.cfg.read_isr) begin
            st_d.rdata = i_in_service;
         end else begin
            st_d.rdata = st_q.pending;
         end
      end
      // Vector byte for the selected level
      if (st_q.cfg.mode86) begin
         st_d.vec_byte = {st_q.cfg.base_hi[7:3], i_vec_level};
      end else if (!i_vec_sel) begin
         st_d.vec_byte = picw_pkg::CALL_CODE;
      end else if (st_q.cfg.adi4) begin
         st_d.vec_byte = {st_q.cfg.base_lo[7:5], i_vec_level,
                          2'h0};
      end else begin
         st_d.vec_byte = {st_q.cfg.base_lo[7:6], i_vec_level,
                          3'h0};
      end
      // Single device always drives; master only for unslaved levels; slave on identity match
      if (st_q.cfg.single) begin
         st_d.vec_drive = 1'b1;
      end else if (is_master) begin
         st_d.vec_drive = ~st_q.cfg.slave_map[i_vec_level];
      end else begin
         st_d.vec_drive = (cas_s == st_q.cfg.slave_id);
      end
      // Status levels registered so each output leaves a flop directly
      st_d.init_done = (st_d.state == PICW_READY);
      st_d.master_out = st_d.cfg.master & st_d.cfg.buffered;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
         st_q.state <= PICW_IDLE;
         st_q.cfg.slave_id <= picw_pkg::SLAVE_ID_RST;
         st_q.cfg.lowest <= picw_pkg::LOWEST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // All outputs come straight from state flops
   assign o_rdata = st_q.rdata;
   assign o_vec_byte = st_q.vec_byte;
   assign o_pending = st_q.pending;
   assign o_init_done = st_q.init_done;
   assign o_level_trig = st_q.cfg.level_trig;
   assign o_special_nest = st_q.cfg.special_nesting_bit;
   assign o_auto_eoi = st_q.cfg.auto_end_bit;
   assign o_mode86 = st_q.cfg.mode86;
   assign o_master = st_q.master_out;
   assign o_slave_program_buffer_enable_oe = st_q.cfg.buffered;
   assign o_smm = st_q.cfg.special_mask_bit;
   assign o_rot_auto_end_bit = st_q.cfg.rot_auto_end_bit;
   assign o_lowest = st_q.cfg.lowest;
   assign o_mask = st_q.cfg.mask;
   assign o_slave_map = st_q.cfg.slave_map;
   assign o_vec_drive = st_q.vec_drive;
   assign o_op = st_q.op;
endmodule

// File: rtl/picw_pkg.sv
package picw_pkg;

   // Word decode fields of the first initialization word
   localparam int unsigned IW1_INIT_BIT = 4;
   localparam int unsigned IW1_LEVEL_TRIGGER_BIT_BIT = 3;
   localparam int unsigned IW1_ADI_BIT = 2;
   localparam int unsigned IW1_SINGLE_DEVICE_BIT_BIT = 1;
   localparam int unsigned IW1_IC4_BIT = 0;

   // Fourth word fields
   localparam int unsigned IW4_SPECIAL_NESTING_BIT_BIT = 4;
   localparam int unsigned IW4_BUF_BIT = 3;
   localparam int unsigned IW4_MS_BIT = 2;
   localparam int unsigned IW4_AUTO_END_BIT_BIT = 1;
   localparam int unsigned IW4_UPM_BIT = 0;

   // Operation word fields
   localparam int unsigned OW_SEL_BIT = 3;
   localparam int unsigned OW2_R_BIT = 7;
   localparam int unsigned OW2_SL_BIT = 6;
   localparam int unsigned OW2_EOI_BIT = 5;
   localparam int unsigned OW3_SPECIAL_MASK_ENABLE_BIT = 6;
   localparam int unsigned OW3_SMM_BIT = 5;
   localparam int unsigned OW3_POLL_BIT = 2;
   localparam int unsigned OW3_RR_BIT = 1;
   localparam int unsigned OW3_RIS_BIT = 0;

   // Reset values and the call opcode
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [2:0] SLAVE_ID_RST = 3'h7;
   localparam logic [2:0] LOWEST_RST = 3'h7;
   localparam logic [7:0] CALL_CODE = 8'hCD;

   // Command decode of rotate, select-level, end bits
   typedef enum logic [2:0] {
      PICW_CMD_ROT_AUTO_END_BIT_CLR = 3'h0,
      PICW_CMD_NS_EOI = 3'h1,
      PICW_CMD_NOP = 3'h2,
      PICW_CMD_SP_EOI = 3'h3,
      PICW_CMD_ROT_AUTO_END_BIT_SET = 3'h4,
      PICW_CMD_ROT_NS_EOI = 3'h5,
      PICW_CMD_SET_PRIO = 3'h6,
      PICW_CMD_ROT_SP_EOI = 3'h7
   } picw_cmd_t;

   // Host bus write/read strobe group
   typedef struct packed {
      logic wr;
      logic rd;
      logic a0;
      logic [7:0] data;
   } picw_bus_t;

   // Configuration that the command words produce
   typedef struct packed {
      logic level_trig;
      logic adi4;
      logic single;
      logic ic4;
      logic [7:0] base_lo;
      logic [7:0] base_hi;
      logic [7:0] slave_map;
      logic [2:0] slave_id;
      logic special_nesting_bit;
      logic buffered;
      logic master;
      logic auto_end_bit;
      logic mode86;
      logic [7:0] mask;
      logic special_mask_bit;
      logic read_isr;
      logic rot_auto_end_bit;
      logic [2:0] lowest;
   } picw_cfg_t;

   // Pulse command produced by the second and third operation words
   typedef struct packed {
      logic valid;
      picw_cmd_t code;
      logic [2:0] level;
      logic poll;
   } picw_op_t;

endpackage

// File: rtl/picw_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs
module picw_sync #(
   parameter int unsigned W = 1
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } picw_sync_st_t;

   picw_sync_st_t st_q;
   picw_sync_st_t st_d;

   // First stage feeds only the second
   always_comb begin
      st_d = st_q;
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.s2;
endmodule

// File: rtl/picw_edge.sv
`timescale 1ns/10ps
// Per-channel request sense: edge latch or level
module picw_edge (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_req,
   input wire logic i_level_mode,
   input wire logic i_rearm,
   input wire logic i_clear,
   output logic o_pending
);
   typedef struct packed {
      logic armed;
      logic latched;
   } picw_edge_st_t;

   picw_edge_st_t st_q;
   picw_edge_st_t st_d;

   // Armed goes high only after the input is seen low; rearm forces a
   // fresh low-to-high transition
   always_comb begin
      st_d = st_q;
      if (!i_req) begin
         st_d.armed = 1'b1;
      end
      if (i_req && st_q.armed) begin
         st_d.latched = 1'b1;
         st_d.armed = 1'b0;
      end else if (i_clear) begin
         st_d.latched = 1'b0;
      end
      if (i_rearm) begin
         st_d.armed = 1'b0;
         st_d.latched = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Level mode bypasses the edge latch entirely
   assign o_pending = i_level_mode ? i_req : st_q.latched;
endmodule

// File: dv/picw_monitor.sv
`timescale 1ns/10ps
// Port-level checks of the command word programming block
module picw_monitor (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wr_n,
   input wire logic [7:0] i_req,
   input wire logic [7:0] i_in_service,
   input wire logic i_vec_sel,
   input wire logic [2:0] i_vec_level,
   input wire logic [7:0] o_vec_byte,
   input wire logic [7:0] o_pending,
   input wire logic o_init_done,
   input wire logic o_level_trig,
   input wire logic o_mode86,
   input wire logic o_smm,
   input wire logic [2:0] o_lowest,
   input wire logic [7:0] o_mask,
   input wire picw_pkg::picw_op_t o_op
);
   logic [3:0] idle_q;
   logic [3:0] idle_d;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // Strobe-high run length; saturates so it never wraps to a false zero
   always_comb begin
      idle_d = 4'h0;
      if (i_wr_n) begin
         idle_d = (idle_q == 4'hF) ? idle_q : idle_q + 4'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      idle_q <= i_srst ? 4'h0 : idle_d;
   end
   // Reset must leave input seven lowest and nothing initialized
   reset_vals_a: assert property (disable iff (1'b0)
      i_srst |=> o_mask == 8'h00 && o_lowest == 3'h7 && !o_init_done)
      else $error("reset state wrong");
   init_clear_a: assert property ($fell(o_init_done) |->
      o_mask == 8'h00 && o_lowest == 3'h7 && !o_smm)
      else $error("first word did not clear state");
   op_pulse_a: assert property (o_op.valid |=> !o_op.valid)
      else $error("command pulse longer than one cycle");
   cfg_stable_a: assert property (idle_q > 4'h6 |->
      $stable(o_mask) && $stable(o_smm) && $stable(o_mode86))
      else $error("configuration moved without a write");
   call_code_a: assert property (!o_mode86 &&
      $past(!o_mode86 && !i_vec_sel && !i_srst) |->
      o_vec_byte == picw_pkg::CALL_CODE)
      else $error("call code byte wrong");
   addr_low_a: assert property (!o_mode86 &&
      $past(!o_mode86 && i_vec_sel && !i_srst) |-> o_vec_byte[1:0] == 2'h0)
      else $error("inserted address bits wrong");
   vec86_a: assert property (o_mode86 &&
      $past(o_mode86 && !i_srst) |-> o_vec_byte[2:0] == $past(i_vec_level))
      else $error("vector level bits wrong");
   level_sense_a: assert property ((o_level_trig &&
      i_req == 8'hFF && i_in_service == 8'h00) [*4] |=> o_pending == 8'hFF)
      else $error("level request not sensed");
endmodule

bind picw_prog picw_monitor u_mon (.i_clk(i_clk), .i_srst(i_srst),
   .i_wr_n(i_wr_n), .i_req(i_req), .i_in_service(i_in_service),
   .i_vec_sel(i_vec_sel), .i_vec_level(i_vec_level),
   .o_vec_byte(o_vec_byte), .o_pending(o_pending),
   .o_init_done(o_init_done), .o_level_trig(o_level_trig),
   .o_mode86(o_mode86), .o_smm(o_smm), .o_lowest(o_lowest),
   .o_mask(o_mask), .o_op(o_op));

// File: dv/picw_host.sv
`timescale 1ns/10ps
// Host side of the command bus; write strobes span 4 clk and read strobes 5 clk so the syncs see them
module picw_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr_n,
   output logic o_rd_n,
   output logic o_cs_n,
   output logic o_a0,
   output logic [7:0] o_data
);
   initial begin
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_cs_n = 1'b1;
      o_a0 = 1'b0;
      o_data = 8'h00;
   end
   // Data held past the synced strobe end, since it is latched late
   task automatic put(input logic a0, input logic [7:0] d);
      @(negedge i_clk);
      o_cs_n = 1'b0;
      o_a0 = a0;
      o_data = d;
      o_wr_n = 1'b0;
      repeat (4) @(negedge i_clk);
      o_wr_n = 1'b1;
      repeat (3) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_data = ~d; // Released bus shows the inverse, not a stale copy
      repeat (3) @(negedge i_clk);
   endtask
   // One status read; the byte is taken before the strobe is let go
   task automatic get(input logic a0, output logic [7:0] d);
      @(negedge i_clk);
      o_cs_n = 1'b0;
      o_a0 = a0;
      o_rd_n = 1'b0;
      repeat (5) @(negedge i_clk);
      d = i_rdata;
      o_rd_n = 1'b1;
      o_cs_n = 1'b1;
      repeat (4) @(negedge i_clk);
   endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the command word programming block
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr_n, rd_n, cs_n, a0, vsel, done, ltrig, nest, auto_end_bit, m86, mst;
   logic oe, special_mask_bit, rot, vdrv, sp_pin;
   logic [2:0] cas;
   logic [7:0] data, req, insv, rdata, vbyte, pend, mask, smap, rd;
   logic [2:0] vlvl, lowest;
   picw_pkg::picw_op_t op, last_op;
   int errors = 0;
   int cmp_count = 0;

   always #10 clk = ~clk;
   // Keeps the latest command pulse, which stands for one cycle only
   always @(posedge clk) if (op.valid === 1'b1) last_op <= op;

   picw_host u_host (.i_clk(clk), .i_rdata(rdata), .o_wr_n(wr_n),
      .o_rd_n(rd_n), .o_cs_n(cs_n), .o_a0(a0), .o_data(data));
   picw_prog u_dut (.i_clk(clk), .i_srst(srst), .i_wr_n(wr_n),
      .i_rd_n(rd_n), .i_cs_n(cs_n), .i_a0(a0), .i_data(data),
      .i_req(req), .i_in_service(insv), .i_cas(cas), .i_slave_program_buffer_enable_pin(sp_pin),
      .i_vec_sel(vsel), .i_vec_level(vlvl), .o_rdata(rdata),
      .o_vec_byte(vbyte), .o_pending(pend), .o_init_done(done),
      .o_level_trig(ltrig), .o_special_nest(nest), .o_auto_eoi(auto_end_bit),
      .o_mode86(m86), .o_master(mst), .o_slave_program_buffer_enable_oe(oe), .o_smm(special_mask_bit),
      .o_rot_auto_end_bit(rot), .o_lowest(lowest), .o_mask(mask),
      .o_slave_map(smap), .o_vec_drive(vdrv), .o_op(op));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wrap_up;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Select-high writes before a first word must be dropped
   task automatic t_reset;
      chk({5'h00, lowest}, 8'h07);
      u_host.put(1'b1, 8'hFF);
      chk({7'h00, done}, 8'h00);
      chk(mask, 8'h00);
   endtask
   // Single device with fourth word, 16-bit host, all fourth bits set
   task automatic t_init86;
      u_host.put(1'b0, 8'hF7);
      u_host.put(1'b1, 8'h5A);
      chk({7'h00, done}, 8'h00);
      u_host.put(1'b1, 8'h1F);
      chk({7'h00, done}, 8'h01);
      chk({3'h0, nest, auto_end_bit, m86, oe, mst}, 8'h1F);
      vsel = 1'b1;
      vlvl = 3'h5;
      cyc(2);
      chk(vbyte, 8'h5D);
      chk({7'h00, vdrv}, 8'h01);
   endtask
   // Cascade, level sensing, no fourth word: its settings must clear
   task automatic t_casc;
      u_host.put(1'b0, 8'hB8);
      u_host.put(1'b1, 8'h00);
      chk({7'h00, done}, 8'h00);
      u_host.put(1'b1, 8'hA5);
      chk({7'h00, done}, 8'h01);
      chk(smap, 8'hA5);
      chk({4'h0, ltrig, auto_end_bit, m86, oe}, 8'h08);
      req = 8'hFF;
      cyc(5);
      chk(pend, 8'hFF);
      req = 8'h00;
      cyc(5);
      chk(pend, 8'h00);
      chk(vbyte, 8'hA8);
      vsel = 1'b0;
      cyc(2);
      chk(vbyte, picw_pkg::CALL_CODE);
      // Strap high makes a master: slaved level 5 is left to its slave
      chk({7'h00, vdrv}, 8'h00);
      vlvl = 3'h6;
      cyc(2);
      chk({7'h00, vdrv}, 8'h01);
      // Strap low makes a slave that answers only its own identity
      sp_pin = 1'b0;
      cas = 3'h5;
      cyc(4);
      chk({7'h00, vdrv}, 8'h01);
      cas = 3'h2;
      cyc(4);
      chk({7'h00, vdrv}, 8'h00);
      sp_pin = 1'b1;
      cas = 3'h0;
   endtask
   // Mask word, mask read, then a restart in the middle of operation
   task automatic t_mask;
      u_host.put(1'b1, 8'h3C);
      chk(mask, 8'h3C);
      u_host.get(1'b1, rd);
      chk(rd, 8'h3C);
      u_host.put(1'b0, 8'h36);
      chk(mask, 8'h00);
      chk({7'h00, done}, 8'h00);
      u_host.put(1'b1, 8'h20);
      chk({7'h00, done}, 8'h01);
      vsel = 1'b1;
      vlvl = 3'h6;
      cyc(2);
      chk(vbyte, 8'h38);
   endtask
   // Edge mode: a restart needs a fresh rising edge to latch again
   task automatic t_edge;
      req = 8'h04;
      cyc(5);
      chk(pend, 8'h04);
      u_host.put(1'b0, 8'h36);
      u_host.put(1'b1, 8'h20);
      chk(pend, 8'h00);
      req = 8'h00;
      cyc(3);
      req = 8'h04;
      cyc(5);
      chk(pend, 8'h04);
      req = 8'h00;
      cyc(5);
      chk(pend, 8'h04);
      insv = 8'h04;
      cyc(2);
      insv = 8'h00;
      cyc(3);
      chk(pend, 8'h00);
   endtask
   // Every rotate/end code, each with its own level
   task automatic t_ops;
      for (int c = 7; c >= 0; c--) begin
         last_op = '0;
         u_host.put(1'b0, {3'(c), 2'b00, 3'(7 - c)});
         chk(last_op, {1'b1, 3'(c), 3'(7 - c), 1'b0});
         if (c == 6) chk({5'h00, lowest}, 8'h01);
         if (c == 4 || c == 0) chk({7'h00, rot}, {7'h00, c == 4});
      end
   endtask
   // Special mask, poll, read select, and what a restart undoes
   task automatic t_special_mask_poll_word;
      u_host.put(1'b0, 8'h68);
      chk({7'h00, special_mask_bit}, 8'h01);
      u_host.put(1'b0, 8'h28);
      chk({7'h00, special_mask_bit}, 8'h01);
      u_host.put(1'b0, 8'h48);
      chk({7'h00, special_mask_bit}, 8'h00);
      last_op = '0;
      u_host.put(1'b0, 8'h0C);
      chk({6'h00, last_op.valid, last_op.poll}, 8'h03);
      insv = 8'h81;
      u_host.put(1'b0, 8'h0B);
      u_host.get(1'b0, rd);
      chk(rd, 8'h81);
      u_host.put(1'b0, 8'h68);
      u_host.put(1'b0, 8'h36);
      u_host.put(1'b1, 8'h20);
      chk({7'h00, special_mask_bit}, 8'h00);
      req = 8'h10;
      cyc(5);
      u_host.get(1'b0, rd);
      chk(rd, 8'h10);
   endtask

   initial begin
      req = 8'h00;
      insv = 8'h00;
      vsel = 1'b0;
      vlvl = 3'h0;
      sp_pin = 1'b1;
      cas = 3'h0;
      last_op = '0;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      t_reset;
      t_init86;
      t_casc;
      t_mask;
      t_edge;
      t_ops;
      t_special_mask_poll_word;
      wrap_up;
   end
   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up;
   end
endmodule
